// ---- core_model.sv ----
// processor side model issuing one access check per call
`timescale 1ns/100ps
module core_model
  import prot_pkg::*;
(
  input  wire logic      i_clock,
  output logic           o_valid,
  output logic [AW-1:0]  o_addr,
  output acc_kind_e      o_kind,
  output logic           o_priv
);
  initial begin
    o_valid = 1'b0;
    o_addr = 32'h0;
    o_kind = ACC_LOAD;
    o_priv = 1'b0;
  end
  task automatic issue(input logic [AW-1:0] a, input acc_kind_e k,
                       input logic p);
    o_valid <= 1'b1;
    o_addr <= a;
    o_kind <= k;
    o_priv <= p;
    @(posedge i_clock);
    o_valid <= 1'b0;
    // inverse so a stale address never passes for a live one
    o_addr <= ~a;
    @(negedge i_clock);
  endtask
endmodule

// ---- prot_pkg.sv ----
// constants and types shared by the region protection block
package prot_pkg;
  localparam int          NUM_REGIONS   = 8;
  localparam int          REG_IDX_W     = 3;
  localparam int          AW            = 32;
  // byte addresses on the register bus
  localparam logic [3:0]  OFS_SELECT    = 4'h0;
  localparam logic [3:0]  OFS_BASE      = 4'h4;
  localparam logic [3:0]  OFS_ATTR      = 4'h8;
  localparam logic [3:0]  OFS_FAULT     = 4'hC;
  // attribute register field positions
  localparam int          XN_BIT        = 28;
  localparam int          AP_HI         = 26;
  localparam int          AP_LO         = 24;
  localparam int          S_BIT         = 18;
  localparam int          C_BIT         = 17;
  localparam int          B_BIT         = 16;
  localparam int          SRD_HI        = 15;
  localparam int          SRD_LO        = 8;
  localparam int          SIZE_HI       = 5;
  localparam int          SIZE_LO       = 1;
  localparam int          EN_BIT        = 0;
  localparam logic [31:0] ATTR_MASK     = 32'h1707FF3F;
  localparam logic [31:0] ATTR_RESET    = 32'h00000000;
  localparam logic [31:0] BASE_RESET    = 32'h00000000;
  localparam logic [4:0]  SIZE_MAX      = 5'h1F;
  localparam logic [5:0]  SUB_SHIFT     = 6'h03;
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;
  // permission codes
  localparam logic [2:0]  AP_NONE       = 3'h0;
  localparam logic [2:0]  AP_PRIV_RW    = 3'h1;
  localparam logic [2:0]  AP_USER_RO    = 3'h2;
  localparam logic [2:0]  AP_FULL       = 3'h3;
  localparam logic [2:0]  AP_RSVD       = 3'h4;
  localparam logic [2:0]  AP_PRIV_RO    = 3'h5;
  localparam logic [2:0]  AP_RO_A       = 3'h6;
  localparam logic [2:0]  AP_RO_B       = 3'h7;

  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_LOAD,
    ACC_STORE
  } acc_kind_e;

  typedef enum logic [1:0] {
    MEM_STRONG,
    MEM_DEVICE,
    MEM_NORMAL_WT,
    MEM_NORMAL_WB
  } mem_type_e;
endpackage

// ---- protect_checker.sv ----
// port assertions for the region protection block
`timescale 1ns/100ps
module protect_checker
  import prot_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_clk_en,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [1:0]  o_avs_response,
  input wire logic        i_acc_valid,
  input wire logic        o_acc_done,
  input wire logic        o_acc_fault,
  input wire logic        o_hard_fault_exception,
  input wire logic [1:0]  o_acc_mem_type,
  input wire logic        o_acc_shareable
);
  wire logic rq;
  wire logic ack;
  assign rq = i_avs_read | i_avs_write;
  assign ack = rq & ~o_avs_waitrequest;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    i_acc_valid && i_clk_en;
  endsequence
  sequence s_answer;
    o_acc_done && o_hard_fault_exception == o_acc_fault;
  endsequence
  a_answer_next: assert property (s_take |=> s_answer)
    else $error("access check not answered next cycle");
  a_done_cause: assert property (o_acc_done |-> $past(i_acc_valid))
    else $error("done without an access");
  a_fault_in_done: assert property (o_acc_fault |-> o_acc_done)
    else $error("fault outside done");
  a_hard_fault_eq: assert property (o_hard_fault_exception == o_acc_fault)
    else $error("hard fault differs from fault");
  a_strong_share: assert property (o_acc_done && !o_acc_fault &&
    !o_acc_mem_type[1] |-> o_acc_shareable) else $error("strong not shared");
  a_wait_rise: assert property ($rose(rq) |-> o_avs_waitrequest)
    else $error("request acked at once");
  a_wait_once: assert property (rq && o_avs_waitrequest && i_clk_en
    |=> !o_avs_waitrequest) else $error("wait longer than one cycle");
  a_unmapped_read: assert property (i_avs_read && ack && i_avs_address[1:0]
    != 2'h0 |-> o_avs_response == 2'h3 && o_avs_readdata == ZERO_WORD)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (ack && i_avs_address[1:0] == 2'h0
    |-> o_avs_response == 2'h0) else $error("mapped access refused");
  a_resv_zero: assert property (i_avs_read && ack &&
    i_avs_address == OFS_ATTR |-> (o_avs_readdata & ~ATTR_MASK) == ZERO_WORD)
    else $error("reserved attribute bits not zero");
endmodule
bind region_protect protect_checker chk (
  .i_clock, .i_rst_n, .i_clk_en, .i_avs_address, .i_avs_read, .i_avs_write,
  .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_acc_valid,
  .o_acc_done, .o_acc_fault, .o_hard_fault_exception, .o_acc_mem_type,
  .o_acc_shareable
);

// ---- region_cfg_if.sv ----
// region configuration carried from the register file to the checker
`timescale 1ns/100ps
interface region_cfg_if;
  import prot_pkg::*;
  logic [31:0] attr [NUM_REGIONS];
  logic [31:0] base [NUM_REGIONS];
  modport src (output attr, output base);
  modport dst (input attr, input base);
endinterface

// ---- region_checker.sv ----
// combinational access check against all regions
`timescale 1ns/100ps
module region_checker
  import prot_pkg::*;
(
  region_cfg_if.dst        cfg,
  input  wire logic [AW-1:0] i_addr,
  input  wire acc_kind_e   i_kind,
  input  wire logic        i_priv,
  output logic             o_hit,
  output logic             o_fault,
  output mem_type_e        o_mem_type,
  output logic             o_shareable,
  output logic [REG_IDX_W-1:0] o_region
);
  logic [NUM_REGIONS-1:0] match;

  // exponent is size code plus one; code 31 covers the whole map
  function automatic logic [5:0] size_exp(input logic [4:0] code);
    size_exp = {1'b0, code} + 6'h01; // RULE_07 RULE_10
  endfunction

  function automatic logic allowed(input logic [2:0] ap,
                                   input logic       priv,
                                   input logic       wr);
    case (ap)
      AP_NONE:    allowed = 1'b0; // RULE_15
      AP_PRIV_RW: allowed = priv; // RULE_16
      AP_USER_RO: allowed = priv | ~wr; // RULE_17
      AP_FULL:    allowed = 1'b1;
      AP_PRIV_RO: allowed = priv & ~wr;
      AP_RO_A,
      AP_RO_B:    allowed = ~wr;
      default:    allowed = 1'b0;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g++) begin : g_reg
      wire logic [31:0] a   = cfg.attr[g];
      wire logic [5:0]  ex  = size_exp(a[SIZE_HI:SIZE_LO]);
      wire logic        all = (a[SIZE_HI:SIZE_LO] == SIZE_MAX); // RULE_09
      wire logic [32:0] msk = ({33{1'b1}} << ex);
      wire logic        am  = all |
        (((i_addr ^ cfg.base[g]) & msk[31:0]) == ZERO_WORD);
      wire logic [5:0]  sh  = ex - SUB_SHIFT;
      wire logic [31:0] sub = i_addr >> sh;
      // lowest mask bit governs the lowest eighth
      wire logic        subregion_off_mask = a[SRD_LO + sub[2:0]]; // RULE_04 RULE_19
      assign match[g] = a[EN_BIT] & am & ~subregion_off_mask; // RULE_22
    end
  endgenerate

  // highest numbered matching region wins on overlap
  always_comb begin
    o_hit    = 1'b0;
    o_region = '0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (match[i]) begin
        o_hit    = 1'b1;
        o_region = REG_IDX_W'(i);
      end
    end
  end

  wire logic [31:0] sel = cfg.attr[o_region];
  wire logic        wr  = (i_kind == ACC_STORE);
  wire logic        xn  = sel[XN_BIT] & (i_kind == ACC_FETCH); // RULE_01
  wire logic        ok  = allowed(sel[AP_HI:AP_LO], i_priv, wr); // RULE_02

  // unmatched accesses fault as well: no background map here
  assign o_fault = ~o_hit | xn | ~ok; // RULE_11

  always_comb begin
    case ({sel[C_BIT], sel[B_BIT]}) // RULE_03
      2'h0:    o_mem_type = MEM_STRONG; // RULE_12
      2'h1:    o_mem_type = MEM_DEVICE;
      2'h2:    o_mem_type = MEM_NORMAL_WT; // RULE_13
      default: o_mem_type = MEM_NORMAL_WB; // RULE_14
    endcase
  end
  assign o_shareable = ~sel[C_BIT] | sel[S_BIT];
endmodule

// ---- region_protect.sv ----
// region attribute registers, avalon slave and access permission check
//
// Functional notes
// RULE_01: execute-never bit 28 blocks instruction fetches
// RULE_02: permission code held in bits 26:24
// RULE_03: shareable, cacheable, bufferable at bits 18,17,16
// RULE_04: bits 15:8 disable subregions when set
// RULE_05: size code held in bits 5:1
// RULE_06: region enable bit 0 resets to zero
// RULE_07: region size is two to code plus one
// RULE_08: software keeps size code at seven or more
// RULE_09: size code 31 covers full 4GB map
// RULE_10: compared base bits start at code plus one
// RULE_11: missing permission raises a permission fault
// RULE_12: cacheable clear: bufferable picks strong or device
// RULE_13: cacheable only: normal write-through, shareable selectable
// RULE_14: cacheable and bufferable: normal write-back
// RULE_15: code 000 denies every access
// RULE_16: code 001 privileged read-write only
// RULE_17: remaining codes per permission table
// RULE_18: violations reported as hard fault exception
// RULE_19: eight subregions, low mask bit lowest
// RULE_20: attribute access uses selected region
// RULE_21: reserved attribute bits read zero, ignore writes
// RULE_22: match needs enable, base, enabled subregion
`timescale 1ns/100ps
module region_protect
  import prot_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_clk_en,
  input  wire logic [3:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest,
  output logic [1:0]                o_avs_response,
  input  wire logic                 i_acc_valid,
  input  wire logic [AW-1:0]        i_acc_addr,
  input  wire acc_kind_e            i_acc_kind,
  input  wire logic                 i_acc_priv,
  output logic                      o_acc_done,
  output logic                      o_acc_fault,
  output logic                      o_hard_fault_exception,
  output logic [1:0]                o_acc_mem_type,
  output logic                      o_acc_shareable
);
  region_cfg_if cfg ();

  logic [31:0]          attr_q [NUM_REGIONS];
  logic [31:0]          base_q [NUM_REGIONS];
  logic [REG_IDX_W-1:0] select_q;
  logic [31:0]          fault_addr_q;
  logic                 fault_seen_q;
  logic                 ack_q;
  logic [31:0]          rdata_q;
  logic [1:0]           resp_q;
  logic                 done_q;
  logic                 fault_q;
  logic                 hf_q;
  logic [1:0]           mtype_q;
  logic                 share_q;

  // byte lanes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // one wait state: the request is answered on the edge after it rises
  wire logic req      = (i_avs_read | i_avs_write) & ~ack_q;
  wire logic hit_sel  = (i_avs_address == OFS_SELECT);
  wire logic hit_base = (i_avs_address == OFS_BASE);
  wire logic hit_attr = (i_avs_address == OFS_ATTR);
  wire logic hit_flt  = (i_avs_address == OFS_FAULT);
  wire logic mapped   = hit_sel | hit_base | hit_attr | hit_flt;
  wire logic [31:0] bm = lane_mask(i_avs_byteenable);
  // a write lands only on the edge that shows waitrequest low
  wire logic do_wr    = i_avs_write & ack_q & i_clk_en;
  wire logic [31:0] cur_attr = attr_q[select_q]; // RULE_20
  wire logic [31:0] cur_base = base_q[select_q];
  // reserved attribute bits are masked off on the way in
  wire logic [31:0] attr_d =
    ((cur_attr & ~bm) | (i_avs_writedata & bm)) & ATTR_MASK; // RULE_21
  wire logic [31:0] base_d =
    (cur_base & ~bm) | (i_avs_writedata & bm);
  wire logic [31:0] sel_d =
    ({{(32-REG_IDX_W){1'b0}}, select_q} & ~bm) | (i_avs_writedata & bm);
  wire logic [31:0] rd_mux =
    hit_sel  ? {{(32-REG_IDX_W){1'b0}}, select_q} :
    hit_base ? cur_base :
    hit_attr ? (cur_attr & ATTR_MASK) : // RULE_21
    hit_flt  ? fault_addr_q : ZERO_WORD;

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign o_avs_readdata    = rdata_q;
  assign o_avs_response    = resp_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= ZERO_WORD;
      resp_q  <= 2'h0;
    end else if (i_clk_en) begin
      ack_q   <= req;
      rdata_q <= (req && i_avs_read) ? rd_mux : rdata_q;
      resp_q  <= (req && !mapped) ? 2'h3 : (req ? 2'h0 : resp_q);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      select_q <= '0;
    end else if (do_wr && hit_sel) begin
      select_q <= sel_d[REG_IDX_W-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g++) begin : g_cfg
      wire logic we = do_wr & (select_q == REG_IDX_W'(g));
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          attr_q[g] <= ATTR_RESET; // RULE_06
          base_q[g] <= BASE_RESET;
        end else begin
          if (we && hit_attr) begin
            attr_q[g] <= attr_d; // RULE_05 RULE_20
          end
          if (we && hit_base) begin
            base_q[g] <= base_d;
          end
        end
      end
      assign cfg.attr[g] = attr_q[g];
      assign cfg.base[g] = base_q[g];
    end
  endgenerate

  logic             chk_hit;
  logic             chk_fault;
  mem_type_e        chk_type;
  logic             chk_share;
  logic [REG_IDX_W-1:0] chk_region;

  region_checker u_check (
    .cfg         (cfg),
    .i_addr      (i_acc_addr),
    .i_kind      (i_acc_kind),
    .i_priv      (i_acc_priv),
    .o_hit       (chk_hit),
    .o_fault     (chk_fault),
    .o_mem_type  (chk_type),
    .o_shareable (chk_share),
    .o_region    (chk_region)
  );

  // check result is registered: answer one cycle after the request
  wire logic acc_take = i_acc_valid & i_clk_en;
  wire logic flt_now  = acc_take & chk_fault; // RULE_11

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_q  <= 1'b0;
      fault_q <= 1'b0;
      hf_q    <= 1'b0;
      mtype_q <= 2'h0;
      share_q <= 1'b0;
    end else if (i_clk_en) begin
      done_q  <= i_acc_valid;
      fault_q <= i_acc_valid & chk_fault;
      hf_q    <= flt_now; // RULE_18
      mtype_q <= i_acc_valid ? chk_type : mtype_q;
      share_q <= i_acc_valid ? chk_share : share_q;
    end
  end

  // fault address latch: new faults win over a software clear
  wire logic flt_clr = do_wr & hit_flt;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_addr_q <= ZERO_WORD;
      fault_seen_q <= 1'b0;
    end else if (flt_now) begin
      fault_addr_q <= i_acc_addr;
      fault_seen_q <= 1'b1;
    end else if (flt_clr) begin
      fault_addr_q <= ZERO_WORD;
      fault_seen_q <= 1'b0;
    end
  end

  assign o_acc_done             = done_q;
  assign o_acc_fault            = fault_q;
  assign o_hard_fault_exception = hf_q;
  assign o_acc_mem_type         = mtype_q;
  assign o_acc_shareable        = share_q;
endmodule

// ---- tb_top.sv ----
// random and corner tests of the region protection block
`timescale 1ns/100ps
module tb_top
  import prot_pkg::*;
;
  logic          i_clock = 1'b0;
  logic          i_rst_n = 1'b0;
  logic [3:0]    i_avs_address = 4'h0;
  logic          i_avs_read = 1'b0;
  logic          i_avs_write = 1'b0;
  logic [31:0]   i_avs_writedata = 32'h0;
  logic          i_clk_en = 1'b1;
  logic [3:0]    i_avs_byteenable = 4'hF;
  logic [31:0]   fa = 32'h0;
  logic [2:0]    ob;
  logic [31:0]   o_avs_readdata, q, at, bs, ad;
  logic          o_avs_waitrequest, i_acc_valid, i_acc_priv, pv;
  logic [1:0]    o_avs_response, o_acc_mem_type, r;
  logic [AW-1:0] i_acc_addr;
  acc_kind_e     i_acc_kind, kd;
  logic          o_acc_done, o_acc_fault, o_hard_fault_exception;
  logic          o_acc_shareable;
  logic [3:0]    ex;
  logic [4:0]    sz;
  int            n_fail = 0;
  int            check_count = 0;
  always #4 i_clock = ~i_clock;
  region_protect DUT (
    .i_clock, .i_rst_n, .i_clk_en, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_acc_valid,
    .i_acc_addr, .i_acc_kind, .i_acc_priv, .o_acc_done, .o_acc_fault,
    .o_hard_fault_exception, .o_acc_mem_type, .o_acc_shareable
  );
  core_model core (.i_clock, .o_valid(i_acc_valid), .o_addr(i_acc_addr),
    .o_kind(i_acc_kind), .o_priv(i_acc_priv));
  function automatic logic [31:0] mask_of(logic [4:0] s);
    return (s == 5'h1F) ? 32'hFFFFFFFF : (32'h2 << s) - 32'h1;
  endfunction
  function automatic logic [3:0] expect_acc(logic [31:0] a, logic [31:0] b,
    logic [31:0] d, acc_kind_e k, logic p);
    logic [31:0] m;
    logic [2:0]  ap, sb;
    logic        rd, wr, hit;
    m = mask_of(a[SIZE_HI:SIZE_LO]);
    sb = 3'((d & m) >> (a[SIZE_HI:SIZE_LO] - 5'h2));
    hit = a[EN_BIT] && (d & ~m) == (b & ~m) && !a[SRD_LO + sb];
    ap = a[AP_HI:AP_LO];
    rd = p ? !(ap inside {AP_NONE, AP_RSVD})
           : (ap inside {AP_USER_RO, AP_FULL, AP_RO_A, AP_RO_B});
    wr = p ? (ap inside {AP_PRIV_RW, AP_USER_RO, AP_FULL}) : ap == AP_FULL;
    return {!hit || (k == ACC_STORE ? !wr : !rd) ||
      (k == ACC_FETCH && a[XN_BIT]),
      !a[C_BIT] | a[S_BIT], a[C_BIT], a[B_BIT]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) n_fail++;
    q = o_avs_readdata;
    r = o_avs_response;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h4ffc0e5b));
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    bus(1'b0, OFS_ATTR, ZERO_WORD);
    chk(q, ATTR_RESET);
    bus(1'b0, 4'h2, ZERO_WORD);
    chk({q[31:2], r}, 32'h3);
    $display("test reset done");
    for (int i = 0; i < 160; i++) begin
      // low sizes stay at seven or more, as software must keep them
      sz = (i % 5 == 0) ? 5'h1F : (i % 5 == 1) ? 5'h07 :
           5'(7 + $urandom % 25);
      at = $urandom;
      at[AP_HI:AP_LO] = 3'(i);
      at[SIZE_HI:SIZE_LO] = sz;
      at[EN_BIT] = (i % 9 != 0);
      bs = $urandom & ~mask_of(sz);
      bus(1'b1, OFS_SELECT, 32'($urandom % 8));
      bus(1'b1, OFS_BASE, bs);
      bus(1'b1, OFS_ATTR, at);
      bus(1'b0, OFS_ATTR, ZERO_WORD);
      chk(q, at & ATTR_MASK);
      for (int j = 0; j < 4; j++) begin
        ad = (j == 3) ? $urandom : bs | ($urandom & mask_of(sz));
        kd = acc_kind_e'($urandom % 3);
        pv = 1'($urandom);
        core.issue(ad, kd, pv);
        ex = expect_acc(at & ATTR_MASK, bs, ad, kd, pv);
        ob = {o_acc_done, o_acc_fault, o_hard_fault_exception};
        chk(ob, {1'b1, ex[3], ex[3]});
        if (ex[3]) fa = ad;
        if (!ex[3]) chk({o_acc_shareable, o_acc_mem_type}, ex[2:0]);
        @(posedge i_clock);
      end
      // the last faulting address is latched for software
      if (i % 16 == 15) begin
        bus(1'b0, OFS_FAULT, ZERO_WORD);
        chk(q, fa);
      end
      // clear before moving on so only one region can ever match
      bus(1'b1, OFS_ATTR, ZERO_WORD);
    end
    $display("test random done");
    // a write to the fault address clears it
    bus(1'b1, OFS_FAULT, ZERO_WORD);
    bus(1'b0, OFS_FAULT, ZERO_WORD);
    chk(q, ZERO_WORD);
    // byte lanes merge into the held base word
    bus(1'b1, OFS_BASE, 32'hFFFFFFFF);
    i_avs_byteenable <= 4'h3;
    bus(1'b1, OFS_BASE, ZERO_WORD);
    i_avs_byteenable <= 4'hF;
    // clock enable low keeps the read pending until it returns
    i_clk_en <= 1'b0;
    fork
      bus(1'b0, OFS_BASE, ZERO_WORD);
      begin
        repeat (3) @(posedge i_clock);
        i_clk_en <= 1'b1;
      end
    join
    chk(q, 32'hFFFF0000);
    $display("test corner done");
    results();
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule
